// *** pkg/acs_pkg.sv ***
// acs_pkg: constants and carriers for the a/d conversion sequencer
// assumes a single 20 MHz system clock; no register bus, bits are ports
package acs_pkg;

  localparam int RES_W       = 12;
  localparam int SAMPLE_CLKS = 4;
  localparam int CONV_CLKS   = 12;
  localparam int TOTAL_CLKS  = SAMPLE_CLKS + CONV_CLKS;
  localparam int CODE_STEPS  = 4096;
  localparam logic [11:0] FULL_SCALE = 12'hFFF;
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [2:0]  DIV_RST    = 3'h0;
  localparam logic [3:0]  SRC_EXT    = 4'h0;
  localparam int SRC_EXT_LAST        = 4'h3;

  typedef struct packed {
    logic       convPowerEn;
    logic       resultFormatSel;
    logic [2:0] convClkDivSel;
    logic [3:0] inputSourceSel;
    logic [3:0] extChannelSel;
    logic [1:0] refSourceSel;
    logic [1:0] pgaGainSel;
    logic [1:0] pgaInputSel;
  } acs_cfg_s;

  typedef struct packed {
    logic        extConnect;
    logic [3:0]  extChannel;
    logic [3:0]  intSignal;
    logic [1:0]  refSel;
    logic [1:0]  pgaGain;
    logic [1:0]  pgaInput;
  } acs_amux_s;

  typedef enum logic [3:0] {
    ACS_OFF    = 4'h1,
    ACS_IDLE   = 4'h2,
    ACS_SAMPLE = 4'h4,
    ACS_CONV   = 4'h8
  } acs_state_e;

endpackage

// *** rtl/acs_clk_div.sv ***
// acs_clk_div: makes one-cycle converter clock ticks, sysclk / 2^sel
// assumes the sequencer restarts it with clr at each conversion start
`timescale 1ns/1ps
`default_nettype none
module acs_clk_div (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic [2:0] divSel,
  output logic            tick
);
  import acs_pkg::*;

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [6:0] lastVal;

  // 000 gives a tick every cycle, 111 every 128 cycles
  always_comb begin
    lastVal = 7'((8'h01 << divSel) - 8'h01);
    tick    = !clr && (cnt_r == lastVal);
    cnt_nxt = (clr || tick) ? 7'h00 : 7'(cnt_r + 7'h01);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// *** rtl/acs_sequencer.sv ***
// acs_sequencer: control for a 12-bit successive-approximation a/d converter
// assumes the analog core returns one comparator decision per conversion tick
// and that software drives the configuration and start bits synchronously
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer #(
  parameter int RW = acs_pkg::RES_W
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire acs_pkg::acs_cfg_s  cfg,
  input  wire logic               startBit,
  input  wire logic               globalIrqEn,
  input  wire logic               convIrqEn,
  input  wire logic               irqFlagClr,
  input  wire logic               cmpAbove,
  output acs_pkg::acs_amux_s      amux,
  output logic                    analogPowerOn,
  output logic                    sampleOn,
  output logic [11:0]             dacCode,
  output logic                    convBusyFlag,
  output logic                    convIrqFlag,
  output logic                    irqOut,
  output logic [7:0]              resultHigh,
  output logic [7:0]              resultLow
);
  import acs_pkg::*;

  acs_state_e state_r;
  acs_state_e state_nxt;
  logic       startPrev_r;
  logic       startPrev_nxt;
  logic       armed_r;
  logic       armed_nxt;
  logic [3:0] tickCnt_r;
  logic [3:0] tickCnt_nxt;
  logic [11:0] sar_r;
  logic [11:0] sar_nxt;
  logic [7:0]  resH_r;
  logic [7:0]  resH_nxt;
  logic [7:0]  resL_r;
  logic [7:0]  resL_nxt;
  logic        irqFlag_r;
  logic        irqFlag_nxt;
  acs_amux_s   amux_r;
  acs_amux_s   amux_nxt;
  logic        tick;
  logic        divClr;
  logic        trigger;
  logic        done;
  logic [3:0]  bitIdx;
  logic [11:0] trialBit;
  logic [11:0] finalCode;

  acs_clk_div u_div (
    .clk    (clk),
    .rst    (rst),
    .clr    (divClr),
    .divSel (cfg.convClkDivSel),
    .tick   (tick)
  );

  // start edge detect: high then low again makes the trigger
  always_comb begin
    startPrev_nxt = startBit;
    armed_nxt     = armed_r;
    if (startBit && !startPrev_r) begin
      armed_nxt = 1'b1;
    end
    trigger = armed_r && startPrev_r && !startBit;
    if (trigger || !cfg.convPowerEn) begin
      armed_nxt = 1'b0;
    end
  end

  // sequence: sample for 4 ticks, then 12 bit trials msb first
  always_comb begin
    state_nxt   = state_r;
    tickCnt_nxt = tickCnt_r;
    sar_nxt     = sar_r;
    divClr      = 1'b0;
    done        = 1'b0;
    bitIdx      = 4'(CONV_CLKS - 1) - tickCnt_r;
    trialBit    = 12'h001 << bitIdx;
    finalCode   = sar_r;
    unique case (state_r)
      ACS_OFF: begin
        if (cfg.convPowerEn) begin
          state_nxt = ACS_IDLE;
        end
      end
      ACS_IDLE: begin
        divClr = 1'b1;
        if (trigger) begin
          state_nxt   = ACS_SAMPLE;
          tickCnt_nxt = 4'h0;
          sar_nxt     = 12'h800;
        end
      end
      ACS_SAMPLE: begin
        if (tick) begin
          tickCnt_nxt = 4'(tickCnt_r + 4'h1);
          if (tickCnt_r == 4'(SAMPLE_CLKS - 1)) begin
            state_nxt   = ACS_CONV;
            tickCnt_nxt = 4'h0;
          end
        end
      end
      ACS_CONV: begin
        if (tick) begin
          // keep the trial bit when input sits above the trial level
          sar_nxt = cmpAbove ? sar_r : (sar_r & ~trialBit);
          if (bitIdx != 4'h0) begin
            sar_nxt = sar_nxt | (trialBit >> 1);
          end
          finalCode   = sar_nxt;
          tickCnt_nxt = 4'(tickCnt_r + 4'h1);
          if (tickCnt_r == 4'(CONV_CLKS - 1)) begin
            state_nxt = ACS_IDLE;
            done      = 1'b1;
          end
        end
      end
      default: state_nxt = ACS_OFF;
    endcase
    // power off aborts anything in flight
    if (!cfg.convPowerEn) begin
      state_nxt = ACS_OFF;
      done      = 1'b0;
    end
  end

  // result and flag update; results land the same edge busy drops
  always_comb begin
    resH_nxt = resH_r;
    resL_nxt = resL_r;
    if (done) begin
      if (cfg.resultFormatSel) begin
        resH_nxt = {4'h0, finalCode[11:8]};
        resL_nxt = finalCode[7:0];
      end else begin
        resH_nxt = finalCode[11:4];
        resL_nxt = {finalCode[3:0], 4'h0};
      end
    end
    // set wins over a clear in the same cycle
    irqFlag_nxt = done || (irqFlag_r && !irqFlagClr);
  end

  // analog mux: internal source opens every external switch
  always_comb begin
    amux_nxt.extConnect = cfg.convPowerEn
                          && (cfg.inputSourceSel <= 4'(SRC_EXT_LAST));
    amux_nxt.extChannel = cfg.extChannelSel;
    amux_nxt.intSignal  = cfg.inputSourceSel;
    amux_nxt.refSel     = cfg.refSourceSel;
    amux_nxt.pgaGain    = cfg.pgaGainSel;
    amux_nxt.pgaInput   = cfg.pgaInputSel;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= ACS_OFF;
      startPrev_r <= 1'b0;
      armed_r     <= 1'b0;
      tickCnt_r   <= 4'h0;
      sar_r       <= RESULT_RST;
      resH_r      <= 8'h00;
      resL_r      <= 8'h00;
      irqFlag_r   <= 1'b0;
      amux_r      <= '0;
    end else begin
      state_r     <= state_nxt;
      startPrev_r <= startPrev_nxt;
      armed_r     <= armed_nxt;
      tickCnt_r   <= tickCnt_nxt;
      sar_r       <= sar_nxt;
      resH_r      <= resH_nxt;
      resL_r      <= resL_nxt;
      irqFlag_r   <= irqFlag_nxt;
      amux_r      <= amux_nxt;
    end
  end

  // outputs straight from registered state; irqOut is also gated by globalIrqEn and convIrqEn
  assign convBusyFlag  = (state_r == ACS_SAMPLE) || (state_r == ACS_CONV);
  assign sampleOn      = (state_r == ACS_SAMPLE);
  assign analogPowerOn = (state_r != ACS_OFF);
  assign dacCode       = sar_r;
  assign convIrqFlag   = irqFlag_r;
  assign irqOut        = irqFlag_r && globalIrqEn && convIrqEn;
  assign resultHigh    = resH_r;
  assign resultLow     = resL_r;
  assign amux          = amux_r;
endmodule
`default_nettype wire

// *** verif/acs_core_model.sv ***
// acs_core_model: ideal sample-hold and comparator behind the sequencer
// assumes vin is an ideal input code and the reference is fixed
`timescale 1ns/1ps
`default_nettype none
module acs_core_model (
  input  wire logic        clk,
  input  wire logic [11:0] vin,
  input  wire logic        sampleOn,
  input  wire logic [11:0] dacCode,
  output logic             cmpAbove
);
  logic [11:0] held = 12'h000;
  // track vin only while sampling, so later vin changes cannot leak into trials
  always @(posedge clk) begin
    if (sampleOn) begin
      held <= vin;
    end
  end
  // input at or above the trial level keeps the bit
  assign cmpAbove = (held >= dacCode);
endmodule
`default_nettype wire

// *** verif/acs_seq_chk.sv ***
// acs_seq_chk: port assertions for the conversion sequencer
// assumes one clock domain; bound to every acs_sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_seq_chk
  import acs_pkg::*;
(
  input wire logic     clk,
  input wire logic     rst,
  input wire acs_cfg_s cfg,
  input wire logic     startBit,
  input wire logic     globalIrqEn,
  input wire logic     convIrqEn,
  input wire acs_amux_s amux,
  input wire logic     analogPowerOn,
  input wire logic     sampleOn,
  input wire logic     convBusyFlag,
  input wire logic     convIrqFlag,
  input wire logic     irqOut,
  input wire logic [7:0] resultHigh,
  input wire logic [7:0] resultLow
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_go;
    $fell(startBit) && !convBusyFlag && analogPowerOn && cfg.convPowerEn;
  endsequence
  sequence s_done;
    $fell(convBusyFlag) && $past(cfg.convPowerEn);
  endsequence
  property p_irq; irqOut == (convIrqFlag && globalIrqEn && convIrqEn); endproperty
  property p_go; s_go |=> convBusyFlag; endproperty
  property p_idle; !convBusyFlag && !$fell(startBit) |=> !convBusyFlag; endproperty
  property p_off; !cfg.convPowerEn |=> !convBusyFlag && !analogPowerOn; endproperty
  property p_smp; $rose(convBusyFlag) && cfg.convClkDivSel == 3'h0 |-> sampleOn[*4] ##1 !sampleOn;
  endproperty
  property p_len; $rose(convBusyFlag) && cfg.convClkDivSel == 3'h1 |-> ##31 convBusyFlag ##1
    !convBusyFlag; endproperty
  property p_int; cfg.inputSourceSel > SRC_EXT_LAST |=> !amux.extConnect; endproperty
  property p_ch; cfg.inputSourceSel <= SRC_EXT_LAST |=> amux.extChannel == $past(cfg.extChannelSel);
  endproperty
  property p_ref; 1'b1 |=> amux.refSel == $past(cfg.refSourceSel); endproperty
  property p_hold; convBusyFlag && $past(convBusyFlag) |-> $stable({resultHigh, resultLow});
  endproperty
  property p_flag; s_done |-> convIrqFlag; endproperty
  property p_fmt; s_done |-> (cfg.resultFormatSel ? resultHigh[7:4] == 4'h0 : resultLow[3:0] == 4'h0);
  endproperty
  a_irq: assert property (p_irq) else $error("irq gate wrong");
  a_go: assert property (p_go) else $error("no start");
  a_idle: assert property (p_idle) else $error("spurious start");
  a_off: assert property (p_off) else $error("busy while off");
  a_smp: assert property (p_smp) else $error("sampling length");
  a_len: assert property (p_len) else $error("busy length");
  a_int: assert property (p_int) else $error("ext pin left on");
  a_ch: assert property (p_ch) else $error("ext channel");
  a_ref: assert property (p_ref) else $error("reference select");
  a_hold: assert property (p_hold) else $error("result moved while busy");
  a_flag: assert property (p_flag) else $error("flag not set");
  a_fmt: assert property (p_fmt) else $error("alignment");
endmodule
bind acs_sequencer acs_seq_chk u_chk (.clk(clk), .rst(rst), .cfg(cfg), .startBit(startBit),
  .globalIrqEn(globalIrqEn), .convIrqEn(convIrqEn), .amux(amux), .analogPowerOn(analogPowerOn),
  .sampleOn(sampleOn), .convBusyFlag(convBusyFlag), .convIrqFlag(convIrqFlag), .irqOut(irqOut),
  .resultHigh(resultHigh), .resultLow(resultLow));
`default_nettype wire

// *** verif/tb_top.sv ***
// tb_top: directed conversions through every divider setting
// assumes the ideal core model answers the comparator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, startBit = 1'b0, gEn = 1'b0, cEn = 1'b0, clr = 1'b0;
  acs_cfg_s cfg = '0;
  logic [11:0] vin = 12'h000, dac;
  logic cmp, pwrOn, smp, busy, flag, irq;
  logic [7:0] hi, lo;
  logic [15:0] e;
  acs_amux_s amux;
  int n_errors = 0, n_checks = 0, n;
  always #25 clk = ~clk;
  acs_sequencer dut (.clk(clk), .rst(rst), .cfg(cfg), .startBit(startBit), .globalIrqEn(gEn),
    .convIrqEn(cEn), .irqFlagClr(clr), .cmpAbove(cmp), .amux(amux), .analogPowerOn(pwrOn),
    .sampleOn(smp), .dacCode(dac), .convBusyFlag(busy), .convIrqFlag(flag), .irqOut(irq),
    .resultHigh(hi), .resultLow(lo));
  acs_core_model core (.clk(clk), .vin(vin), .sampleOn(smp), .dacCode(dac), .cmpAbove(cmp));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // bounded wait for a busy level, counting edges
  task automatic waitBusy(input logic lvl);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (busy !== lvl && n < 5000);
    if (busy !== lvl) begin
      n_errors++;
      results();
    end
  endtask
  // full high-then-low pulse, as software writes it
  task automatic pulse;
    @(negedge clk) startBit = 1'b1;
    @(negedge clk) startBit = 1'b0;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check({hi, lo}, 16'h0000);
    check({12'h000, busy, flag, irq, pwrOn}, 16'h0000);
    @(negedge clk) cfg.convPowerEn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      cfg.convClkDivSel = i[2:0];
      cfg.resultFormatSel = i[0];
      cfg.inputSourceSel = i[3:0];
      cfg.extChannelSel = 4'hF - i[3:0];
      cfg.refSourceSel = i[1:0];
      cfg.pgaGainSel = i[1:0];
      cfg.pgaInputSel = 2'h3 - i[1:0];
      {cEn, gEn} = i[1:0];
      vin = 12'hFFF - 12'(i * 12'h249); // full scale first, zero last
      clr = 1'b1;
      @(negedge clk) clr = 1'b0;
      pulse();
      waitBusy(1'b1);
      check(amux.extConnect, 16'(i < 4));
      check(amux.refSel, 16'(i[1:0]));
      check({amux.pgaGain, amux.pgaInput}, 16'({i[1:0], 2'h3 - i[1:0]}));
      check(amux.intSignal, 16'(i[3:0]));
      if (i < 4) check(amux.extChannel, 16'(4'hF - i[3:0]));
      if (i == 1) pulse(); // a start while busy must be ignored
      if (i != 1) waitBusy(1'b0);
      if (i != 1) check(16'(n), 16'(16 << i));
      if (i == 1) waitBusy(1'b0);
      e = cfg.resultFormatSel ? {4'h0, vin} : {vin, 4'h0};
      check({hi, lo}, e);
      check(flag, 16'h1);
      check(irq, 16'(gEn & cEn));
      repeat (3) @(posedge clk);
      #1 check(busy, 16'h0);
    end
    // power off in mid-conversion aborts without result or flag
    // a fresh input level makes any leaked result visible
    @(negedge clk) cfg.convClkDivSel = 3'h2;
    cfg.inputSourceSel = 4'h0;
    vin = 12'h5A5;
    clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    pulse();
    waitBusy(1'b1);
    @(negedge clk) cfg.convPowerEn = 1'b0;
    waitBusy(1'b0);
    check(16'(n), 16'h0001);
    check(amux.extConnect, 16'h0000);
    check({flag, pwrOn}, 16'h0);
    check({hi, lo}, e);
    pulse();
    repeat (3) @(posedge clk);
    #1 check(busy, 16'h0);
    results();
  end
endmodule
`default_nettype wire
